// ---- rtl/hsf_pkg.sv ----
package hsf_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_FREQ_MHZ     = 100;
  localparam int unsigned DEGLITCH_TIME_NS = 3000;
  localparam int unsigned DEGLITCH_CYC     = (DEGLITCH_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam int unsigned GLITCH_W         = 9;
  localparam int unsigned RETRY_W          = 16;
  localparam logic [RETRY_W-1:0] RETRY_CYC_DEF = 16'h03E8;

  // ****************************************
  // analog code widths and limits
  // ****************************************
  localparam int unsigned TEMP_W = 8;
  localparam int unsigned CURR_W = 10;
  localparam logic [TEMP_W-1:0] ABS_THERMAL_LIMIT   = 8'hAF;
  localparam logic [TEMP_W-1:0] THERMAL_HYSTERESIS  = 8'h14;
  localparam logic [TEMP_W:0]   REL_THERMAL_LIMIT   = 9'h03C;
  localparam logic [CURR_W-1:0] OVERCURRENT_THRESH  = 10'h200;
  localparam logic [2:0]        FOLDBACK_COUNT      = 3'h7;

  // ****************************************
  // register port
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE  = 4'h8;
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;

  typedef enum logic [1:0] {
    VER_SHUTDOWN,
    VER_FOLDBACK,
    VER_REGULATE
  } hsf_version_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ON,
    ST_FAULT
  } hsf_state_type;

  // sticky event bits, same layout in status and mask
  typedef struct packed {
    logic [2:0] unused;
    logic       foldback;
    logic       fault_entry;
    logic       overcurrent;
    logic       rel_thermal;
    logic       abs_thermal;
  } hsf_event_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } hsf_bus_type;

endpackage

// ---- rtl/hsf_protect.sv ----
`timescale 1ns/1ns
// Operation
// - thermal or overcurrent trip forces switch off, fault
// - fault state shows fault on sense output
// - release needs hold low, timer done, faults clear
// - thermal fault: absolute or relative limit exceeded
// - absolute fault holds until below limit minus hysteresis
// - relative fault clears when recovery time elapses
// - shutdown versions turn off at overcurrent threshold
// - overcurrent counts only after 3 us persistence
// - regulating version limits, turns off on thermal
// - regulating version flags fault while limiting
// - foldback version halves threshold after seven faults
// - standby or clean on/off restores threshold, count
// - other versions never reduce the threshold
// - fault state selects fault current on sense
// - hold high latches off; low retries automatically
module hsf_protect
  import hsf_pkg::*;
#(
  parameter hsf_version_type    VERSION   = VER_SHUTDOWN,
  parameter logic [RETRY_W-1:0] RETRY_CYC = RETRY_CYC_DEF
) (
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_SRST,
  input  wire logic              I_EN,
  input  wire logic              I_LATCH,
  input  wire logic              I_STANDBY,
  input  wire logic [TEMP_W-1:0] I_FET_TEMP,
  input  wire logic [TEMP_W-1:0] I_CTRL_TEMP,
  input  wire logic [CURR_W-1:0] I_LOAD_CURRENT,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic                   O_SWITCH_ON,
  output logic                   O_SENSE_FAULT_SEL,
  output logic                   O_LIMITING,
  output logic                   O_FOLDBACK,
  output logic [DATA_W-1:0]      O_RDATA,
  output logic                   O_IRQ
);

  // ****************************************
  // state and next values
  // ****************************************
  hsf_bus_type       bus;
  hsf_state_type     st_q, st_d;
  logic [RETRY_W-1:0]  timer_q, timer_d;
  logic [GLITCH_W-1:0] glitch_q, glitch_d;
  logic              abs_q, abs_d, rel_q, rel_d, oc_q, oc_d;
  logic              lim_q, lim_d;
  logic [2:0]        fold_cnt_q, fold_cnt_d;
  logic              sw_q, sw_d, sns_q, sns_d, fold_q, fold_d, irq_q, irq_d;
  logic [DATA_W-1:0] rdata_q, rdata_d, sts_q, sts_d, mask_q, mask_d;
  hsf_event_type     evt;
  logic [TEMP_W:0]   temp_diff;
  logic [CURR_W-1:0] oc_thresh;
  logic              over, oc_evt, abs_trip, rel_trip, fault_trip;
  logic              any_fault, release_ok, timer_done, clean_cycle;

  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // ****************************************
  // detectors
  // ****************************************
  always_comb begin
    temp_diff = {1'b0, I_FET_TEMP} - {1'b0, I_CTRL_TEMP};
    abs_trip  = I_FET_TEMP > ABS_THERMAL_LIMIT;
    // diff wraps when controller is hotter; bit TEMP_W marks that case
    rel_trip  = !temp_diff[TEMP_W] && (temp_diff > REL_THERMAL_LIMIT);
    oc_thresh = fold_q ? (OVERCURRENT_THRESH >> 1) : OVERCURRENT_THRESH;
    over      = sw_q && (I_LOAD_CURRENT >= oc_thresh);
    oc_evt    = over && (glitch_q == GLITCH_W'(DEGLITCH_CYC - 1));
    timer_done = (timer_q == '0);
    fault_trip = abs_trip || rel_trip || (oc_evt && VERSION != VER_REGULATE);
    any_fault  = abs_q || rel_q || oc_q;
    release_ok = !I_LATCH && timer_done && !any_fault && !fault_trip;

    glitch_d = '0;
    if (over) begin
      glitch_d = (glitch_q == GLITCH_W'(DEGLITCH_CYC)) ? glitch_q : glitch_q + 1'b1;
    end

    // absolute fault keeps until temperature drops by the hysteresis
    abs_d = abs_trip || (abs_q && I_FET_TEMP >= ABS_THERMAL_LIMIT - THERMAL_HYSTERESIS);
    // relative fault has no hysteresis, only the recovery time
    rel_d = rel_trip || (rel_q && !timer_done);
    oc_d  = (oc_evt && VERSION != VER_REGULATE) || (oc_q && !timer_done);
    lim_d = (VERSION == VER_REGULATE) && over
            && (glitch_d == GLITCH_W'(DEGLITCH_CYC));
  end

  // ****************************************
  // switch control
  // ****************************************
  always_comb begin
    st_d    = st_q;
    timer_d = timer_q;
    case (st_q)
      ST_IDLE: begin
        if (fault_trip) st_d = ST_FAULT;
        else if (I_EN) st_d = ST_ON;
      end
      ST_ON: begin
        if (fault_trip) st_d = ST_FAULT;
        else if (!I_EN) st_d = ST_IDLE;
      end
      ST_FAULT: begin
        if (!timer_done) timer_d = timer_q - 1'b1;
        if (release_ok) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (fault_trip && st_q != ST_FAULT) timer_d = RETRY_CYC;
    clean_cycle = (st_q == ST_ON) && (st_d == ST_IDLE);

    fold_cnt_d = fold_cnt_q;
    if (I_STANDBY || clean_cycle) begin
      fold_cnt_d = '0;
    end else if (st_q != ST_FAULT && st_d == ST_FAULT && fold_cnt_q != FOLDBACK_COUNT) begin
      fold_cnt_d = fold_cnt_q + 1'b1;
    end
    fold_d = (VERSION == VER_FOLDBACK) && (fold_cnt_d == FOLDBACK_COUNT);
    sw_d   = (st_d == ST_ON);
    sns_d  = (st_d == ST_FAULT) || lim_d;
  end

  // ****************************************
  // registers and interrupt
  // ****************************************
  always_comb begin
    evt             = '0;
    evt.abs_thermal = abs_trip && !abs_q;
    evt.rel_thermal = rel_trip && !rel_q;
    evt.overcurrent = oc_evt;
    evt.fault_entry = (st_q != ST_FAULT) && (st_d == ST_FAULT);
    evt.foldback    = fold_d && !fold_q;
    mask_d = (bus.wr && bus.addr == REG_MASK) ? bus.wdata : mask_q;
    // a new event in the clearing cycle survives
    sts_d  = (sts_q & ~((bus.wr && bus.addr == REG_STATUS) ? bus.wdata : '0)) | evt;
    irq_d  = |(sts_d & mask_d);
    rdata_d = '0;
    if (bus.rd) begin
      case (bus.addr)
        REG_STATUS: rdata_d = sts_q;
        REG_MASK:   rdata_d = mask_q;
        REG_STATE:  rdata_d = {fold_cnt_q, lim_q, any_fault, st_q, sw_q};
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      st_q       <= ST_IDLE;
      timer_q    <= '0;
      glitch_q   <= '0;
      abs_q      <= 1'b0;
      rel_q      <= 1'b0;
      oc_q       <= 1'b0;
      lim_q      <= 1'b0;
      fold_cnt_q <= '0;
      sw_q       <= 1'b0;
      sns_q      <= 1'b0;
      fold_q     <= 1'b0;
      sts_q      <= '0;
      mask_q     <= MASK_RESET;
      irq_q      <= 1'b0;
      rdata_q    <= '0;
    end else begin
      st_q       <= st_d;
      timer_q    <= timer_d;
      glitch_q   <= glitch_d;
      abs_q      <= abs_d;
      rel_q      <= rel_d;
      oc_q       <= oc_d;
      lim_q      <= lim_d;
      fold_cnt_q <= fold_cnt_d;
      sw_q       <= sw_d;
      sns_q      <= sns_d;
      fold_q     <= fold_d;
      sts_q      <= sts_d;
      mask_q     <= mask_d;
      irq_q      <= irq_d;
      rdata_q    <= rdata_d;
    end
  end

  assign O_SWITCH_ON       = sw_q;
  assign O_SENSE_FAULT_SEL = sns_q;
  assign O_LIMITING        = lim_q;
  assign O_FOLDBACK        = fold_q;
  assign O_RDATA           = rdata_q;
  assign O_IRQ             = irq_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_fault_off;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (st_q == ST_FAULT) |-> !O_SWITCH_ON;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("switch on in fault state");

  property p_trip_enter;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (abs_trip || rel_trip) |=> (st_q == ST_FAULT) && !O_SWITCH_ON;
  endproperty
  a_trip_enter: assert property (p_trip_enter) else $error("thermal trip not handled");

  property p_sense_fault;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (st_q == ST_FAULT) |-> O_SENSE_FAULT_SEL;
  endproperty
  a_sense_fault: assert property (p_sense_fault) else $error("no fault indication");

  property p_release;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (st_q == ST_FAULT) ##1 (st_q != ST_FAULT) |-> $past(release_ok);
  endproperty
  a_release: assert property (p_release) else $error("fault released early");

  property p_abs_hold;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      abs_q && (I_FET_TEMP >= ABS_THERMAL_LIMIT - THERMAL_HYSTERESIS) |=> abs_q;
  endproperty
  a_abs_hold: assert property (p_abs_hold) else $error("absolute fault cleared early");

  property p_rel_clear;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      rel_q && timer_done && !rel_trip |=> !rel_q;
  endproperty
  a_rel_clear: assert property (p_rel_clear) else $error("relative fault stuck");

  property p_deglitch;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      $rose(oc_q) |-> $past(over, 1) && $past(over, 2) && $past(over, 8);
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("overcurrent not filtered");

  property p_regulate;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      O_LIMITING |-> O_SENSE_FAULT_SEL && !oc_q && (VERSION == VER_REGULATE);
  endproperty
  a_regulate: assert property (p_regulate) else $error("limiting misreported");

  property p_foldback;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      O_FOLDBACK |-> (VERSION == VER_FOLDBACK) && (fold_cnt_q == FOLDBACK_COUNT);
  endproperty
  a_foldback: assert property (p_foldback) else $error("threshold reduced wrongly");

  property p_standby;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      I_STANDBY |=> (fold_cnt_q == '0) && !O_FOLDBACK;
  endproperty
  a_standby: assert property (p_standby) else $error("foldback not restored");

  property p_timer_restart;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (st_q != ST_FAULT) ##1 (st_q == ST_FAULT) |-> (timer_q == RETRY_CYC);
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

  property p_follow_enable;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (st_q != ST_FAULT) && !fault_trip |=> (O_SWITCH_ON == $past(I_EN));
  endproperty
  a_follow_enable: assert property (p_follow_enable) else $error("enable ignored");

  property p_oc_off;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      oc_q |-> !O_SWITCH_ON && (st_q == ST_FAULT);
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("on with overcurrent fault");

  property p_sense_source;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      O_SENSE_FAULT_SEL |-> (st_q == ST_FAULT) || O_LIMITING;
  endproperty
  a_sense_source: assert property (p_sense_source) else $error("wrong sense source");

  property p_release_sense;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (st_q == ST_FAULT) ##1 (st_q == ST_IDLE) |-> !O_SENSE_FAULT_SEL;
  endproperty
  a_release_sense: assert property (p_release_sense) else $error("indication kept");

  property p_clean_cycle;
    @(posedge I_CORE_CLK) disable iff (I_SRST)
      (st_q == ST_ON) ##1 (st_q == ST_IDLE) |-> (fold_cnt_q == '0) && !O_FOLDBACK;
  endproperty
  a_clean_cycle: assert property (p_clean_cycle) else $error("count not cleared");

  c_fault: cover property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (st_q == ST_ON) ##1 (st_q == ST_FAULT));
  c_retry: cover property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (st_q == ST_FAULT) ##1 (st_q == ST_IDLE) ##1 (st_q == ST_ON));
  c_fold: cover property (@(posedge I_CORE_CLK) disable iff (I_SRST) $rose(O_FOLDBACK));
  c_limit: cover property (@(posedge I_CORE_CLK) disable iff (I_SRST) $rose(O_LIMITING));
  c_clean: cover property (@(posedge I_CORE_CLK) disable iff (I_SRST)
    (st_q == ST_ON) ##1 (st_q == ST_IDLE));

endmodule

// ---- verif/hsf_host.sv ----
`timescale 1ns/1ns
module hsf_host (
  input  wire logic i_core_clk,
  input  wire logic i_want_en,
  input  wire logic i_want_latch,
  output logic      o_en,
  output logic      o_latch
);
  // firmware pins only move at clock edges, one cycle behind the request
  always_ff @(posedge i_core_clk) begin
    o_en    <= i_want_en;
    o_latch <= i_want_latch;
  end
endmodule

// ---- verif/high_side_fault_protection_tb.sv ----
`timescale 1ns/1ns
module high_side_fault_protection_tb;
  import hsf_pkg::*;
  localparam logic [RETRY_W-1:0] RCYC = 16'h0014;
  logic              I_CORE_CLK = 1'b0;
  logic              I_SRST     = 1'b1;
  logic              want_en    = 1'b0;
  logic              want_latch = 1'b0;
  logic              I_STANDBY  = 1'b0;
  logic              I_WR       = 1'b0;
  logic              I_RD       = 1'b0;
  logic [3:0]        I_ADDR     = 4'h0;
  logic [7:0]        I_WDATA    = 8'h00;
  logic [7:0]        fet        = 8'h00;
  logic [7:0]        ctrl       = 8'h00;
  logic [9:0]        cur        = 10'h000;
  logic              en;
  logic              latch;
  logic              sw;
  logic              sen;
  logic              fb;
  logic              sw_c;
  logic              sen_c;
  logic              lim_c;
  logic              fb_c;
  logic              irq;
  logic [7:0]        rdata;
  int                n_errors   = 0;
  int                compares   = 0;
  int                cyc        = 0;
  int                i;

  always #5 I_CORE_CLK = ~I_CORE_CLK;

  hsf_host u_hsf_host (.i_core_clk(I_CORE_CLK), .i_want_en(want_en),
    .i_want_latch(want_latch), .o_en(en), .o_latch(latch));

  hsf_protect #(.VERSION(VER_FOLDBACK), .RETRY_CYC(RCYC)) u_hsf_protect (
    .I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .I_EN(en), .I_LATCH(latch),
    .I_STANDBY(I_STANDBY), .I_FET_TEMP(fet), .I_CTRL_TEMP(ctrl),
    .I_LOAD_CURRENT(cur), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_SWITCH_ON(sw), .O_SENSE_FAULT_SEL(sen), .O_LIMITING(),
    .O_FOLDBACK(fb), .O_RDATA(rdata), .O_IRQ(irq));

  // current-regulating variant beside it, same stimulus
  hsf_protect #(.VERSION(VER_REGULATE), .RETRY_CYC(RCYC)) u_hsf_protect_lim (
    .I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .I_EN(en), .I_LATCH(latch),
    .I_STANDBY(I_STANDBY), .I_FET_TEMP(fet), .I_CTRL_TEMP(ctrl),
    .I_LOAD_CURRENT(cur), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_SWITCH_ON(sw_c), .O_SENSE_FAULT_SEL(sen_c), .O_LIMITING(lim_c),
    .O_FOLDBACK(fb_c), .O_RDATA(), .O_IRQ());

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] ev(input logic ab, rl, oc, fe);
    hsf_event_type e;
    e = '0;
    e.abs_thermal = ab;
    e.rel_thermal = rl;
    e.overcurrent = oc;
    e.fault_entry = fe;
    return e;
  endfunction

  task automatic final_report;
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge I_CORE_CLK);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CORE_CLK);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'b1;
    @(posedge I_CORE_CLK);
    I_WR    <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge I_CORE_CLK);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_CORE_CLK);
    I_RD   <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge I_CORE_CLK) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      final_report;
    end
  end

  initial begin
    void'($urandom(32'h02a50baa));
    tick(8);
    I_SRST <= 1'b0;
    rdc(REG_STATUS, 8'h00);
    rdc(REG_MASK, MASK_RESET);
    rdc(REG_STATE, 8'h00);
    rdc(4'hC, 8'h00);
    wr(REG_MASK, 8'h01);
    want_en <= 1'b1;
    want_latch <= 1'b1;
    // controller kept warm so the absolute steps stay below the relative limit
    ctrl <= 8'h80;
    for (i = 0; i < 20; i++) begin
      tick(1);
      fet <= 8'(8'h50 + $urandom % 60);
      cur <= 10'($urandom % 256);
    end
    tick(3);
    #1 chk({sw, sen}, 8'h02);
    tick(1);
    fet <= 8'hB0;
    tick(2);
    #1 chk({sw, sen}, 8'h01);
    rdc(REG_STATUS, ev(1, 0, 0, 1));
    chk(irq, 1'b1);
    tick(1);
    fet <= 8'h9B;
    tick(40);
    rdc(REG_STATE, 8'h2C);
    tick(1);
    fet <= 8'h9A;
    tick(6);
    #1 chk(sen, 1'b1);
    rdc(REG_STATE, 8'h24);
    tick(1);
    want_latch <= 1'b0;
    tick(6);
    #1 chk({sw, sen}, 8'h02);
    wr(REG_STATUS, 8'h0F);
    rdc(REG_STATUS, 8'h00);
    chk(irq, 1'b0);
    tick(1);
    ctrl <= 8'h5D;
    tick(2);
    ctrl <= 8'h80;
    tick(10);
    #1 chk(sen, 1'b1);
    tick(int'(RCYC) + 6);
    #1 chk(sw, 1'b1);
    rdc(REG_STATUS, ev(0, 1, 0, 1));
    tick(1);
    cur <= 10'h200;
    tick(250);
    #1 chk(sw, 1'b1);
    chk({sw_c, sen_c, lim_c}, 8'h04);
    tick(60);
    #1 chk({sw, sen}, 8'h01);
    chk({sw_c, sen_c, lim_c}, 8'h07);
    cur <= 10'h000;
    for (i = 3; i < 8; i++) begin
      tick(int'(RCYC) + 8);
      fet <= 8'hB0;
      tick(3);
      fet <= 8'h90;
      #1 chk(fb, 8'(i >= 6));
      chk(fb_c, 8'h00);
    end
    tick(int'(RCYC) + 8);
    cur <= 10'h100;
    tick(310);
    #1 chk(sw, 1'b0);
    chk({sw_c, fb_c}, 8'h02);
    cur <= 10'h000;
    I_STANDBY <= 1'b1;
    tick(1);
    I_STANDBY <= 1'b0;
    tick(3);
    #1 chk(fb, 1'b0);
    // one fault, then a clean on and off cycle clears the count again
    tick(int'(RCYC) + 10);
    fet <= 8'hB0;
    tick(3);
    fet <= 8'h90;
    tick(int'(RCYC) + 8);
    rdc(REG_STATE, 8'h23);
    want_en <= 1'b0;
    tick(4);
    rdc(REG_STATE, 8'h00);
    final_report;
  end
endmodule
